/* hdl/counter_array.sv */
// counter array top: apb slave, timebase, counter and modules
`timescale 1ns/1ns
module counter_array #(
  parameter int NUM_MODULES = 3
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // count sources and cpu idle
  input wire logic i_timer0_overflow,
  input wire logic i_external_count_input,
  input wire logic i_ext_osc,
  input wire logic i_cpu_idle,
  // frequency outputs
  output logic [NUM_MODULES-1:0] o_module_output_pin,
  // interrupts
  output logic o_irq
);
  // module count bounded by the register map
  if (NUM_MODULES < 1 || NUM_MODULES > 3) begin : g_bad_modules
    $error("NUM_MODULES must be 1 to 3");
  end

  localparam int NM = NUM_MODULES;

  // register file
  logic [7:0] mode_r;
  logic [7:0] cnt_low_r;
  logic [7:0] cnt_high_r;
  logic [15:0] count_r;
  logic [7:0] snapshot_r;
  logic ovf_flag_r;
  logic [NM-1:0] mod_status_r;
  logic [NM:0] irq_status;
  logic [NM:0] irq_mask_r;
  logic [31:0] prdata_r;
  // timebase
  logic [3:0] div12_r;
  logic [3:0] div4_r;
  logic [1:0] eci_sync_r;
  logic eci_prev_r;
  logic [1:0] osc_sync_r;
  logic osc_prev_r;
  logic [2:0] osc_div_r;
  logic eci_fall;
  logic osc_rise;
  logic [2:0] tsel;
  logic tick;
  logic tick_raw;
  logic halted;
  logic ovf_set;
  // module wiring
  logic [7:0] mm_mode [NM];
  logic [7:0] mm_cmp_low [NM];
  logic [7:0] mm_cmp_high [NM];
  logic [NM-1:0] mm_match;
  logic [NM-1:0] wr_mm_mode;
  logic [NM-1:0] wr_mm_low;
  logic [NM-1:0] wr_mm_high;
  // bus decode
  logic acc;
  logic wr;
  logic rd_setup;
  logic wr_mode;
  logic wr_cnt_low;
  logic wr_cnt_high;
  logic wr_status;
  logic wr_mask;
  logic [31:0] rd_val;
  logic rd_ok;

  function automatic logic [11:0] mod_addr(input int idx,
                                           input logic [11:0] ofs);
    mod_addr = counter_array_pkg::ADDR_MOD_BASE +
               12'(idx) * counter_array_pkg::MOD_STRIDE + ofs;
  endfunction : mod_addr

  // one-cycle strobe from a synchronised level and its delayed copy
  function automatic logic edge_of(input logic now, input logic prev,
                                   input logic rising);
    edge_of = rising ? (now && !prev) : (!now && prev);
  endfunction : edge_of

  assign acc = i_psel && i_penable;
  assign wr = acc && i_pwrite;
  // read data and the snapshot are both taken in the setup cycle
  assign rd_setup = i_psel && !i_penable && !i_pwrite;
  assign wr_mode = wr && i_paddr == counter_array_pkg::ADDR_MODE;
  assign wr_cnt_low = wr && i_paddr == counter_array_pkg::ADDR_CNT_LOW;
  assign wr_cnt_high = wr && i_paddr == counter_array_pkg::ADDR_CNT_HIGH;
  assign wr_status = wr && i_paddr == counter_array_pkg::ADDR_IRQ_STATUS;
  assign wr_mask = wr && i_paddr == counter_array_pkg::ADDR_IRQ_MASK;
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !rd_ok;
  assign o_prdata = prdata_r;

  assign tsel = mode_r[counter_array_pkg::MODE_TB_MSB:
                       counter_array_pkg::MODE_TB_LSB];
  assign halted = mode_r[counter_array_pkg::MODE_IDLE_HALT] && i_cpu_idle;

  // prescalers run freely
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || div12_r == counter_array_pkg::DIV12_LAST) begin
      div12_r <= 4'h0;
    end else begin
      div12_r <= div12_r + 4'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset || div4_r == counter_array_pkg::DIV4_LAST) begin
      div4_r <= 4'h0;
    end else begin
      div4_r <= div4_r + 4'h1;
    end
  end

  // external pin: two-stage sync, edge seen on second stage
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      eci_sync_r <= 2'b11;
      eci_prev_r <= 1'b1;
    end else begin
      eci_sync_r <= {eci_sync_r[0], i_external_count_input};
      eci_prev_r <= eci_sync_r[1];
    end
  end

  // external oscillator synchronised, rising edges divided by 8
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      osc_sync_r <= 2'b00;
      osc_prev_r <= 1'b0;
    end else begin
      osc_sync_r <= {osc_sync_r[0], i_ext_osc};
      osc_prev_r <= osc_sync_r[1];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      osc_div_r <= 3'h0;
    end else if (osc_rise) begin
      osc_div_r <= osc_div_r + 3'h1;
    end
  end

  assign eci_fall = edge_of(eci_sync_r[1], eci_prev_r, 1'b0);
  assign osc_rise = edge_of(osc_sync_r[1], osc_prev_r, 1'b1);

  always_comb begin
    tick_raw = 1'b0;
    unique case (tsel)
      counter_array_pkg::TB_DIV12: begin
        tick_raw = (div12_r == counter_array_pkg::DIV12_LAST);
      end
      counter_array_pkg::TB_DIV4: begin
        tick_raw = (div4_r == counter_array_pkg::DIV4_LAST);
      end
      counter_array_pkg::TB_T0_OVF: begin
        tick_raw = i_timer0_overflow;
      end
      counter_array_pkg::TB_EXT_EDGE: begin
        tick_raw = eci_fall;
      end
      counter_array_pkg::TB_SYSCLK: begin
        tick_raw = 1'b1;
      end
      counter_array_pkg::TB_OSC_DIV8: begin
        tick_raw = osc_rise &&
                   (osc_div_r == counter_array_pkg::OSC_DIV_LAST);
      end
      default: begin
        tick_raw = 1'b0;
      end
    endcase
  end
  assign tick = tick_raw && !halted;

  // counter ignores bus reads entirely; a byte write stops that tick
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cnt_low_r <= counter_array_pkg::BYTE_RESET;
    end else if (wr_cnt_low) begin
      cnt_low_r <= i_pwdata[7:0];
    end else if (tick && !wr_cnt_high) begin
      cnt_low_r <= cnt_low_r + 8'h01;
    end
  end

  // high byte carries when the low byte wraps
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cnt_high_r <= counter_array_pkg::BYTE_RESET;
    end else if (wr_cnt_high) begin
      cnt_high_r <= i_pwdata[7:0];
    end else if (tick && !wr_cnt_low && cnt_low_r == 8'hFF) begin
      cnt_high_r <= cnt_high_r + 8'h01;
    end
  end
  assign count_r = {cnt_high_r, cnt_low_r};
  assign ovf_set = tick && !wr_cnt_low && !wr_cnt_high &&
    (count_r == counter_array_pkg::COUNT_MAX);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      snapshot_r <= 8'h00;
    end else if (rd_setup &&
                 i_paddr == counter_array_pkg::ADDR_CNT_LOW) begin
      snapshot_r <= cnt_high_r;
    end
  end

  // counter mode register
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      mode_r <= 8'h00;
    end else if (wr_mode) begin
      mode_r <= i_pwdata[7:0];
    end
  end

  // overflow flag: the set wins over either software clear
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ovf_flag_r <= 1'b0;
    end else if (ovf_set) begin
      ovf_flag_r <= 1'b1;
    end else if (wr_status && i_pwdata[0]) begin
      ovf_flag_r <= 1'b0;
    end else if (wr_mode &&
                 !i_pwdata[counter_array_pkg::MODE_OVF_FLAG]) begin
      ovf_flag_r <= 1'b0;
    end
  end

  // module match bits, set wins over write-one-to-clear
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      mod_status_r <= '0;
    end else begin
      for (int k = 0; k < NM; k++) begin
        if (mm_match[k]) begin
          mod_status_r[k] <= 1'b1;
        end else if (wr_status && i_pwdata[k+1]) begin
          mod_status_r[k] <= 1'b0;
        end
      end
    end
  end
  // status: bit 0 overflow flag, bit 1+n module match
  assign irq_status = {mod_status_r, ovf_flag_r};

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      irq_mask_r <= '0;
    end else if (wr_mask) begin
      irq_mask_r <= i_pwdata[NM:0];
    end
  end

  // overflow gated by its own enable as well as the mask
  assign o_irq = (irq_status[0] && irq_mask_r[0] &&
                  mode_r[counter_array_pkg::MODE_OVF_IRQ_EN]) ||
                 |(irq_status[NM:1] & irq_mask_r[NM:1]);

  genvar g;
  generate
    for (g = 0; g < NM; g++) begin : g_mod
      assign wr_mm_mode[g] = wr && i_paddr ==
        mod_addr(g, counter_array_pkg::MOD_OFS_MODE);
      assign wr_mm_low[g] = wr && i_paddr ==
        mod_addr(g, counter_array_pkg::MOD_OFS_CMP_LOW);
      assign wr_mm_high[g] = wr && i_paddr ==
        mod_addr(g, counter_array_pkg::MOD_OFS_CMP_HIGH);
      freq_output_module u_mod (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_tick(tick),
        .i_count_low(count_r[7:0]),
        .i_wr_mode(wr_mm_mode[g]),
        .i_wr_cmp_low(wr_mm_low[g]),
        .i_wr_cmp_high(wr_mm_high[g]),
        .i_wdata(i_pwdata[7:0]),
        .o_mode(mm_mode[g]),
        .o_cmp_low(mm_cmp_low[g]),
        .o_cmp_high(mm_cmp_high[g]),
        .o_pin(o_module_output_pin[g]),
        .o_match(mm_match[g])
      );
    end
  endgenerate

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (i_paddr == counter_array_pkg::ADDR_MODE) begin
      rd_val[7:0] = mode_r;
      rd_val[counter_array_pkg::MODE_OVF_FLAG] = irq_status[0];
    end else if (i_paddr == counter_array_pkg::ADDR_CNT_LOW) begin
      rd_val[7:0] = count_r[7:0];
    end else if (i_paddr == counter_array_pkg::ADDR_CNT_HIGH) begin
      rd_val[7:0] = snapshot_r;
    end else if (i_paddr == counter_array_pkg::ADDR_IRQ_STATUS) begin
      rd_val[NM:0] = irq_status;
    end else if (i_paddr == counter_array_pkg::ADDR_IRQ_MASK) begin
      rd_val[NM:0] = irq_mask_r;
    end else begin
      rd_ok = 1'b0;
      for (int k = 0; k < NM; k++) begin
        if (i_paddr == mod_addr(k, counter_array_pkg::MOD_OFS_MODE)) begin
          rd_val[7:0] = mm_mode[k];
          rd_ok = 1'b1;
        end
        if (i_paddr == mod_addr(k, counter_array_pkg::MOD_OFS_CMP_LOW)) begin
          rd_val[7:0] = mm_cmp_low[k];
          rd_ok = 1'b1;
        end
        if (i_paddr == mod_addr(k, counter_array_pkg::MOD_OFS_CMP_HIGH)) begin
          rd_val[7:0] = mm_cmp_high[k];
          rd_ok = 1'b1;
        end
      end
    end
  end

  // read data stands from setup until the next read setup
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_r <= rd_val;
    end
  end
endmodule : counter_array

/* hdl/counter_array_pkg.sv */
// constants for the counter array with frequency-output modules
// Functional notes
// - sixteen-bit counter in two byte registers
// - low read latches high byte snapshot
// - reads never disturb counting
// - three-bit select picks count source
// - count external falling edges, one count per edge
// - oscillator divided by eight, synchronised
// - wrap to zero sets overflow flag
// - flag, enable and mask bit 0 raise interrupt request
// - software clears the overflow flag
// - idle halt clear keeps counting in idle
// - compare high byte holds toggle spacing
// - low compare match inverts module pin
// - match adds high byte to low compare
package counter_array_pkg;
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_CNT_LOW = 12'h004;
  localparam logic [11:0] ADDR_CNT_HIGH = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
  localparam logic [11:0] ADDR_MOD_BASE = 12'h040;
  // per module: mode, compare low, compare high
  localparam logic [11:0] MOD_STRIDE = 12'h010;
  localparam logic [11:0] MOD_OFS_MODE = 12'h000;
  localparam logic [11:0] MOD_OFS_CMP_LOW = 12'h004;
  localparam logic [11:0] MOD_OFS_CMP_HIGH = 12'h008;
  // counter mode register fields
  localparam int MODE_OVF_IRQ_EN = 0;
  localparam int MODE_TB_LSB = 1;
  localparam int MODE_TB_MSB = 3;
  localparam int MODE_IDLE_HALT = 7;
  localparam int MODE_OVF_FLAG = 8;
  // module mode register fields
  localparam int MM_PWM_SELECT = 1;
  localparam int MM_TOGGLE_EN = 2;
  localparam int MM_COMPARE_EN = 6;
  localparam logic [7:0] MM_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // timebase encodings
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4 = 3'h1;
  localparam logic [2:0] TB_T0_OVF = 3'h2;
  localparam logic [2:0] TB_EXT_EDGE = 3'h3;
  localparam logic [2:0] TB_SYSCLK = 3'h4;
  localparam logic [2:0] TB_OSC_DIV8 = 3'h5;
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam logic [2:0] OSC_DIV_LAST = 3'h7;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
endpackage : counter_array_pkg

/* hdl/freq_output_module.sv */
// one compare module running in frequency-output mode
`timescale 1ns/1ns
module freq_output_module (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // counter state
  input wire logic i_tick,
  input wire logic [7:0] i_count_low,
  // register writes
  input wire logic i_wr_mode,
  input wire logic i_wr_cmp_low,
  input wire logic i_wr_cmp_high,
  input wire logic [7:0] i_wdata,
  // register contents, pin and match strobe
  output logic [7:0] o_mode,
  output logic [7:0] o_cmp_low,
  output logic [7:0] o_cmp_high,
  output logic o_pin,
  output logic o_match
);
  logic freq_mode;
  logic match;
  logic [7:0] mode_r;
  logic [7:0] cmp_low_r;
  logic [7:0] cmp_high_r;
  logic pin_r;

  assign freq_mode = mode_r[counter_array_pkg::MM_COMPARE_EN] &
                     mode_r[counter_array_pkg::MM_TOGGLE_EN] &
                     mode_r[counter_array_pkg::MM_PWM_SELECT];
  // compare against the count before this tick moves it
  assign match = freq_mode && i_tick &&
                 (cmp_low_r == i_count_low);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      mode_r <= counter_array_pkg::MM_RESET;
    end else if (i_wr_mode) begin
      mode_r <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cmp_high_r <= counter_array_pkg::BYTE_RESET;
    end else if (i_wr_cmp_high) begin
      cmp_high_r <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cmp_low_r <= counter_array_pkg::BYTE_RESET;
    end else if (i_wr_cmp_low) begin
      cmp_low_r <= i_wdata;
    end else if (match) begin
      cmp_low_r <= cmp_low_r + cmp_high_r;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pin_r <= 1'b0;
    end else if (match) begin
      pin_r <= ~pin_r;
    end
  end

  assign o_mode = mode_r;
  assign o_cmp_low = cmp_low_r;
  assign o_cmp_high = cmp_high_r;
  assign o_pin = pin_r;
  assign o_match = match;
endmodule : freq_output_module

/* tb/count_source_model.sv */
// model of the external count pin and external oscillator
`timescale 1ns/1ns
module count_source_model (
  // clock
  input wire logic i_sys_clk,
  // pins
  output logic o_ext_count,
  output logic o_ext_osc
);
  initial begin
    o_ext_count = 1'b1;
    o_ext_osc = 1'b0;
  end
  // falls at one eighth of the clock, idle high
  task automatic falls(input int n);
    repeat (n) begin
      o_ext_count <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      o_ext_count <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
    end
  endtask : falls
  // oscillator at a quarter of the clock, then still
  task automatic osc(input int n);
    repeat (n) begin
      o_ext_osc <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      o_ext_osc <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
    end
    repeat (4) @(posedge i_sys_clk);
  endtask : osc
endmodule : count_source_model

/* tb/counter_array_props.sv */
// port-level property checker for the counter array
`timescale 1ns/1ns
module counter_array_props #(
  parameter int NUM_MODULES = 3
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // idle, pins and interrupt
  input wire logic i_cpu_idle,
  input wire logic [NUM_MODULES-1:0] o_module_output_pin,
  input wire logic o_irq
);
  logic wr;
  logic [2:0] sel_r;
  logic halt_r;
  logic [31:0] mask_r;
  logic [2:0] age_r;
  assign wr = i_psel && i_penable && i_pwrite;
  // shadow of mode and mask, cycles since a mode write
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sel_r <= 3'h0;
      halt_r <= 1'b0;
      mask_r <= 32'h0000_0000;
      age_r <= 3'h0;
    end else begin
      if (wr && i_paddr == counter_array_pkg::ADDR_MODE) begin
        sel_r <= i_pwdata[3:1];
        halt_r <= i_pwdata[7];
        age_r <= 3'h0;
      end else if (age_r != 3'h7) begin
        age_r <= age_r + 3'h1;
      end
      if (wr && i_paddr == counter_array_pkg::ADDR_IRQ_MASK) begin
        mask_r <= i_pwdata;
      end
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  sequence pins_hold3;
    $stable(o_module_output_pin) [*3];
  endsequence
  chk_ready_zero_wait: assert property (o_pready)
    else $error("pready low");
  chk_err_access_only: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("pslverr outside access");
  chk_err_reads_zero: assert property (
    o_pslverr && !i_pwrite |-> o_prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_irq_reset_low: assert property ($fell(i_reset) |-> !o_irq)
    else $error("irq high after reset");
  chk_irq_mask_gate: assert property (mask_r == 0 |-> !o_irq)
    else $error("irq with mask clear");
  chk_reserved_hold: assert property (
    sel_r[2:1] == 2'b11 && age_r >= 3 |-> $stable(o_module_output_pin))
    else $error("pin moved on reserved timebase");
  chk_idle_halt_hold: assert property (
    halt_r && age_r >= 3 && i_cpu_idle && $past(i_cpu_idle)
    |-> $stable(o_module_output_pin))
    else $error("pin moved while halted");
  chk_div4_spacing: assert property (
    sel_r == counter_array_pkg::TB_DIV4 && age_r == 3'h7
    && $changed(o_module_output_pin) |=> pins_hold3)
    else $error("toggles closer than four clocks");
endmodule : counter_array_props

/* tb/tb.sv */
// self-checking bench for the counter array
`timescale 1ns/1ns
module tb;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic i_timer0_overflow = 1'b0;
  logic i_cpu_idle = 1'b0;
  logic ext_cnt;
  logic ext_osc;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic [2:0] pins;
  logic o_irq;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int n_compared = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  counter_array #(.NUM_MODULES(3)) counter_array_i (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_timer0_overflow(i_timer0_overflow),
    .i_external_count_input(ext_cnt), .i_ext_osc(ext_osc),
    .i_cpu_idle(i_cpu_idle), .o_module_output_pin(pins), .o_irq(o_irq));
  count_source_model count_source_model_i (
    .i_sys_clk(i_sys_clk), .o_ext_count(ext_cnt), .o_ext_osc(ext_osc));
  task automatic stop_test;
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdv(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rd, e);
  endtask : rdv
  // settled look at the interrupt line between edges
  task automatic irq_is(input logic e);
    @(negedge i_sys_clk);
    cmp({31'h0, o_irq}, {31'h0, e});
    @(posedge i_sys_clk);
  endtask : irq_is
  task automatic t_regs;
    rdv(counter_array_pkg::ADDR_MODE, 32'h0000_0000);
    rdv(12'h0F0, 32'h0000_0000);
    cmp({31'h0, err}, 32'h0000_0001);
  endtask : t_regs
  task automatic t_snapshot;
    wr(counter_array_pkg::ADDR_MODE, 32'h0000_000C);
    wr(counter_array_pkg::ADDR_CNT_HIGH, 32'h0000_0012);
    wr(counter_array_pkg::ADDR_CNT_LOW, 32'h0000_00FE);
    repeat (20) @(posedge i_sys_clk);
    rdv(counter_array_pkg::ADDR_CNT_LOW, 32'h0000_00FE);
    wr(counter_array_pkg::ADDR_CNT_HIGH, 32'h0000_0055);
    rdv(counter_array_pkg::ADDR_CNT_HIGH, 32'h0000_0012);
    rdv(counter_array_pkg::ADDR_CNT_LOW, 32'h0000_00FE);
    rdv(counter_array_pkg::ADDR_CNT_HIGH, 32'h0000_0055);
    wr(counter_array_pkg::ADDR_CNT_HIGH, 32'h0000_0012);
    wr(counter_array_pkg::ADDR_MODE, 32'h0000_0008);
    rdv(counter_array_pkg::ADDR_CNT_LOW, 32'h0000_00FF);
    rdv(counter_array_pkg::ADDR_CNT_HIGH, 32'h0000_0012);
  endtask : t_snapshot
  // counts gained between two low-byte reads w+3 clocks apart, plus any stimulus time
  task automatic t_src(input logic [2:0] c, input logic h, input int w,
                       input int n);
    logic [7:0] a;
    wr(counter_array_pkg::ADDR_MODE, {24'h0, h, 3'h0, c, 1'b0});
    apb(1'b0, counter_array_pkg::ADDR_CNT_LOW, 32'h0000_0000);
    a = rd[7:0];
    repeat (w) @(posedge i_sys_clk);
    if (c == counter_array_pkg::TB_T0_OVF) begin
      repeat (n) begin
        i_timer0_overflow <= 1'b1;
        @(posedge i_sys_clk);
        i_timer0_overflow <= 1'b0;
        @(posedge i_sys_clk);
      end
    end
    if (c == counter_array_pkg::TB_EXT_EDGE) count_source_model_i.falls(n);
    if (c == counter_array_pkg::TB_OSC_DIV8) count_source_model_i.osc(8 * n);
    apb(1'b0, counter_array_pkg::ADDR_CNT_LOW, 32'h0000_0000);
    cmp({24'h0, rd[7:0] - a}, n);
  endtask : t_src
  task automatic t_ovf;
    wr(counter_array_pkg::ADDR_MODE, 32'h0000_000C);
    wr(counter_array_pkg::ADDR_CNT_HIGH, 32'h0000_00FF);
    wr(counter_array_pkg::ADDR_CNT_LOW, 32'h0000_00FF);
    wr(counter_array_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    wr(counter_array_pkg::ADDR_MODE, 32'h0000_0009);
    wr(counter_array_pkg::ADDR_MODE, 32'h0000_010D);
    rdv(counter_array_pkg::ADDR_MODE, 32'h0000_010D);
    irq_is(1'b1);
    rdv(counter_array_pkg::ADDR_MODE, 32'h0000_010D);
    wr(counter_array_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    irq_is(1'b0);
    wr(counter_array_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    irq_is(1'b1);
    wr(counter_array_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
    irq_is(1'b0);
    rdv(counter_array_pkg::ADDR_MODE, 32'h0000_000D);
  endtask : t_ovf
  task automatic wait_pin(output int n);
    logic p;
    p = pins[0];
    n = 0;
    do begin
      @(negedge i_sys_clk);
      n++;
    end while (pins[0] === p && n < 400);
    @(posedge i_sys_clk);
  endtask : wait_pin
  task automatic t_freq;
    int n;
    wr(counter_array_pkg::ADDR_CNT_LOW, 32'h0000_0000);
    wr(counter_array_pkg::ADDR_MOD_BASE + 12'h004, 32'h0000_0010);
    wr(counter_array_pkg::ADDR_MOD_BASE + 12'h008, 32'h0000_0005);
    wr(counter_array_pkg::ADDR_MOD_BASE, 32'h0000_0046);
    wr(counter_array_pkg::ADDR_MODE, 32'h0000_0002);
    wait_pin(n);
    cmp({31'h0, pins[0]}, 32'h0000_0001);
    wait_pin(n);
    cmp(n, 20);
    rdv(counter_array_pkg::ADDR_MOD_BASE + 12'h004,
        32'h0000_001A);
    rdv(counter_array_pkg::ADDR_IRQ_STATUS, 32'h0000_0002);
    wr(counter_array_pkg::ADDR_MODE, 32'h0000_000C);
    wait_pin(n);
    cmp(n, 400);
  endtask : t_freq
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(posedge i_sys_clk);
    t_regs;
    t_snapshot;
    i_cpu_idle <= 1'b1;
    t_src(counter_array_pkg::TB_SYSCLK, 1'b0, 0, 3);
    i_cpu_idle <= 1'b0;
    t_src(counter_array_pkg::TB_DIV4, 1'b1, 9, 3);
    t_src(counter_array_pkg::TB_DIV12, 1'b0, 33, 3);
    t_src(counter_array_pkg::TB_T0_OVF, 1'b0, 0, 3);
    t_src(counter_array_pkg::TB_EXT_EDGE, 1'b0, 0, 5);
    t_src(counter_array_pkg::TB_OSC_DIV8, 1'b0, 0, 2);
    i_cpu_idle <= 1'b1;
    t_src(3'h4, 1'b1, 0, 0);
    i_cpu_idle <= 1'b0;
    t_ovf;
    t_freq;
    stop_test;
  end
  initial begin
    #100000;
    num_errors++;
    stop_test;
  end
endmodule : tb
bind counter_array counter_array_props #(.NUM_MODULES(NUM_MODULES))
  counter_array_props_i (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_cpu_idle(i_cpu_idle),
  .o_module_output_pin(o_module_output_pin), .o_irq(o_irq));
